// ==== hw/sph_pkg.sv ====
// Package: register map, field positions and states of the serial peripheral host.
// Functional notes
// - Both ends move serial data through an eight-bit shift register.
// - Shift out MSb first, one bit per clock, shifting the received bit into LSb.
// - Change output on the configured edge, sample input on the opposite edge.
// - The master starts each exchange by making the clock; slaves never drive it.
// - Master and slave use the same clock idle polarity before any exchange.
// - After eight clock cycles both shift registers have swapped contents.
// - A select period may hold any number of clock cycles; the host sends whole bytes of eight cycles unless enable is cleared mid-byte.
// - With no more data, the master stops the clock, then deselects the slave.
// - Only one slave select is asserted at a time, one line per slave.
// - An unselected slave ignores clock and data and leaves its output undriven; the bench model toggles it every aclk cycle instead.
package sph_pkg;
  localparam logic [4:0] OFF_CTRL    = 5'h00;
  localparam logic [4:0] OFF_STATUS  = 5'h04;
  localparam logic [4:0] OFF_TXDATA  = 5'h08;
  localparam logic [4:0] OFF_RXDATA  = 5'h0c;
  localparam logic [4:0] OFF_DIV     = 5'h10;
  localparam int         CTRL_EN     = 0;
  localparam int         CTRL_CPOL   = 1;
  localparam int         CTRL_CPHA   = 2;
  localparam int         CTRL_HOLD   = 3;
  localparam int         CTRL_SEL_LO = 4;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_FULL     = 1;
  localparam int         ST_WRITE_COLLISION_FLAG     = 2;
  localparam int         ST_SEL      = 3;
  localparam logic [7:0] DIV_RST     = 8'h03;
  localparam logic [3:0] LAST_EDGE   = 4'hf;
  localparam logic [4:0] BYTE_EDGES  = 5'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SPH_IDLE  = 3'b000,
    SPH_SETUP = 3'b001,
    SPH_XFER  = 3'b010,
    SPH_END   = 3'b011
  } sph_state_e;
  typedef enum logic [2:0] {
    SPH_R_CTRL = 3'b000,
    SPH_R_STAT = 3'b001,
    SPH_R_TX   = 3'b010,
    SPH_R_RX   = 3'b011,
    SPH_R_DIV  = 3'b100,
    SPH_R_NONE = 3'b111
  } sph_reg_e;
endpackage : sph_pkg

// ==== hw/sph_sync.sv ====
// Two-flip-flop synchroniser for an input from outside the clock domain.
`timescale 1ns/1ps
module sph_sync (
  input  wire logic aclk,    // System clock.
  input  wire logic aresetn, // Synchronous reset, active low.
  input  wire logic din,     // Asynchronous level.
  output logic      dout     // Level in the aclk domain.
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule : sph_sync

// ==== hw/sph_master.sv ====
// Serial peripheral host: AXI4-Lite register slave and byte-wide link master.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sph_master
  import sph_pkg::*;
#(
  parameter int NSEL = 4 // Number of slave select lines, a power of two.
) (
  input  wire logic              aclk,                 // System clock, 20 MHz.
  input  wire logic              aresetn,              // Synchronous reset, active low.
  input  wire logic [4:0]        awaddr,               // Write address.
  input  wire logic              awvalid,              // Write address valid.
  output logic                   awready,              // Write address ready.
  input  wire logic [31:0]       wdata,                // Write data.
  input  wire logic [3:0]        wstrb,                // Write byte strobes.
  input  wire logic              wvalid,               // Write data valid.
  output logic                   wready,               // Write data ready.
  output logic [1:0]             bresp,                // Write response.
  output logic                   bvalid,               // Write response valid.
  input  wire logic              bready,               // Write response ready.
  input  wire logic [4:0]        araddr,               // Read address.
  input  wire logic              arvalid,              // Read address valid.
  output logic                   arready,              // Read address ready.
  output logic [31:0]            rdata,                // Read data.
  output logic [1:0]             rresp,                // Read response.
  output logic                   rvalid,               // Read data valid.
  input  wire logic              rready,               // Read data ready.
  output logic                   dev_serial_clock_pin, // Serial clock to the device.
  output logic                   dev_serial_in_pin,    // Data to the device input.
  input  wire logic              dev_serial_out_pin,   // Data from the device output.
  output logic [NSEL-1:0]        dev_select_in_pin_n   // Slave selects, active low.
);
  localparam int SEL_W = (NSEL > 1) ? $clog2(NSEL) : 1;

  function automatic sph_reg_e sph_dec(input logic [4:0] a);
    unique case (a)
      OFF_CTRL:   sph_dec = SPH_R_CTRL;
      OFF_STATUS: sph_dec = SPH_R_STAT;
      OFF_TXDATA: sph_dec = SPH_R_TX;
      OFF_RXDATA: sph_dec = SPH_R_RX;
      OFF_DIV:    sph_dec = SPH_R_DIV;
      default:    sph_dec = SPH_R_NONE;
    endcase
  endfunction : sph_dec

  logic              miso_s;
  logic              aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [4:0]        awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]        bresp_nxt, rresp_nxt;
  logic [31:0]       rdata_nxt, rd_word;
  logic              wr_do, tx_wr, tx_go, tx_coll, rd_take, rx_rd;
  sph_reg_e          wr_sel, rd_sel;
  logic              en_r, en_nxt, cpol_r, cpol_nxt, cpha_r, cpha_nxt, hold_r, hold_nxt;
  logic [SEL_W-1:0]  sel_idx_r, sel_idx_nxt;
  logic [7:0]        div_r, div_nxt, rxbuf_r, rxbuf_nxt;
  logic              write_collision_flag_r, write_collision_flag_nxt, full_r, full_nxt;
  sph_state_e        state_r, state_nxt;
  logic [7:0]        cnt_r, cnt_nxt, sh_r, sh_nxt;
  logic [3:0]        edge_r, edge_nxt;
  logic              sclk_nxt, mosi_nxt, done_r, done_nxt, tick;
  logic [NSEL-1:0]   seln_nxt;

  // The device output changes on our change edge; two sync stages cost two
  // cycles, so the half period must be at least three cycles.
  sph_sync u_miso_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (dev_serial_out_pin),
    .dout    (miso_s)
  );

  // Bus slave: address and data are taken in either order, answered together.
  assign wr_do   = aw_held_r && w_held_r && !bvalid;
  assign wr_sel  = sph_dec(awaddr_r);
  assign rd_take = arvalid && arready;
  assign rd_sel  = sph_dec(araddr);
  assign tx_wr   = wr_do && (wr_sel == SPH_R_TX) && wstrb_r[0];
  assign tx_go   = tx_wr && en_r && !write_collision_flag_r && (state_r == SPH_IDLE);
  assign tx_coll = tx_wr && en_r && (state_r != SPH_IDLE);
  assign rx_rd   = rd_take && (rd_sel == SPH_R_RX);

  always_comb begin
    rd_word = 32'h0;
    unique case (rd_sel)
      SPH_R_CTRL: begin
        rd_word[CTRL_EN]                  = en_r;
        rd_word[CTRL_CPOL]                = cpol_r;
        rd_word[CTRL_CPHA]                = cpha_r;
        rd_word[CTRL_HOLD]                = hold_r;
        rd_word[CTRL_SEL_LO +: SEL_W]     = sel_idx_r;
      end
      SPH_R_STAT: begin
        rd_word[ST_BUSY] = (state_r != SPH_IDLE);
        rd_word[ST_FULL] = full_r;
        rd_word[ST_WRITE_COLLISION_FLAG] = write_collision_flag_r;
        rd_word[ST_SEL]  = !(&dev_select_in_pin_n);
      end
      SPH_R_RX:  rd_word[7:0] = rxbuf_r;
      SPH_R_DIV: rd_word[7:0] = div_r;
      default:   rd_word = 32'h0;
    endcase
  end

  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid && !bready;
    bresp_nxt   = bresp;
    rvalid_nxt  = rvalid && !rready;
    rdata_nxt   = rdata;
    rresp_nxt   = rresp;
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = awaddr;
    end
    if (wvalid && wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
    end
    if (wr_do) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_sel == SPH_R_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = (rd_sel == SPH_R_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt  = !w_held_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 5'h00;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0;
      rresp     <= RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready   <= awready_nxt;
      wready    <= wready_nxt;
      bvalid    <= bvalid_nxt;
      bresp     <= bresp_nxt;
      arready   <= arready_nxt;
      rvalid    <= rvalid_nxt;
      rdata     <= rdata_nxt;
      rresp     <= rresp_nxt;
    end
  end

  // Control registers. Polarity, phase and select index only change while idle,
  // so the slave never sees the clock convention move under a byte.
  always_comb begin
    en_nxt      = en_r;
    cpol_nxt    = cpol_r;
    cpha_nxt    = cpha_r;
    hold_nxt    = hold_r;
    sel_idx_nxt = sel_idx_r;
    div_nxt     = div_r;
    write_collision_flag_nxt    = write_collision_flag_r;
    full_nxt    = full_r;
    rxbuf_nxt   = rxbuf_r;
    if (wr_do && wstrb_r[0]) begin
      if (wr_sel == SPH_R_CTRL) begin
        en_nxt   = wdata_r[CTRL_EN];
        hold_nxt = wdata_r[CTRL_HOLD];
        if (state_r == SPH_IDLE) begin
          cpol_nxt    = wdata_r[CTRL_CPOL];
          cpha_nxt    = wdata_r[CTRL_CPHA];
          sel_idx_nxt = wdata_r[CTRL_SEL_LO +: SEL_W];
        end
      end
      if (wr_sel == SPH_R_DIV) begin
        div_nxt = wdata_r[7:0];
      end
      if (wr_sel == SPH_R_STAT && wdata_r[ST_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_nxt = 1'b0;
      end
    end
    if (rx_rd) begin
      full_nxt = 1'b0;
    end
    // Hardware sets win over software clears in the same cycle.
    if (tx_coll) begin
      write_collision_flag_nxt = 1'b1;
    end
    if (done_nxt) begin
      full_nxt  = 1'b1;
      rxbuf_nxt = sh_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r      <= 1'b0;
      cpol_r    <= 1'b0;
      cpha_r    <= 1'b0;
      hold_r    <= 1'b0;
      sel_idx_r <= '0;
      div_r     <= DIV_RST;
      write_collision_flag_r    <= 1'b0;
      full_r    <= 1'b0;
      rxbuf_r   <= 8'h00;
    end else begin
      en_r      <= en_nxt;
      cpol_r    <= cpol_nxt;
      cpha_r    <= cpha_nxt;
      hold_r    <= hold_nxt;
      sel_idx_r <= sel_idx_nxt;
      div_r     <= div_nxt;
      write_collision_flag_r    <= write_collision_flag_nxt;
      full_r    <= full_nxt;
      rxbuf_r   <= rxbuf_nxt;
    end
  end

  // Link engine. One half period of the serial clock is div_r + 1 cycles.
  always_comb begin
    state_nxt = state_r;
    edge_nxt  = edge_r;
    sh_nxt    = sh_r;
    sclk_nxt  = dev_serial_clock_pin;
    mosi_nxt  = dev_serial_in_pin;
    done_nxt  = 1'b0;
    tick      = (cnt_r == 8'h00);
    cnt_nxt   = tick ? div_r : cnt_r - 8'h01;
    unique case (state_r)
      SPH_IDLE: begin
        sclk_nxt = cpol_r;
        cnt_nxt  = div_r;
        if (tx_go) begin
          state_nxt = SPH_SETUP;
          sh_nxt    = wdata_r[7:0];
          mosi_nxt  = wdata_r[7];
          edge_nxt  = 4'h0;
        end
      end
      SPH_SETUP: begin
        if (tick) begin
          state_nxt = SPH_XFER;
        end
      end
      SPH_XFER: begin
        if (tick) begin
          sclk_nxt = !dev_serial_clock_pin;
          edge_nxt = edge_r + 4'h1;
          if (edge_r[0] == cpha_r) begin
            sh_nxt = {sh_r[6:0], miso_s};
          end else begin
            mosi_nxt = sh_r[7];
          end
          if (edge_r == LAST_EDGE) begin
            state_nxt = SPH_END;
            done_nxt  = 1'b1;
          end
        end
      end
      SPH_END: begin
        if (tick) begin
          state_nxt = SPH_IDLE;
        end
      end
      default: state_nxt = SPH_IDLE;
    endcase
    if (!en_nxt) begin
      state_nxt = SPH_IDLE;
      sclk_nxt  = cpol_r;
      mosi_nxt  = dev_serial_in_pin;
      done_nxt  = 1'b0;
    end
    // Hold keeps the slave selected across bytes so a frame can be any length.
    seln_nxt = '1;
    if (en_nxt && (state_nxt != SPH_IDLE || hold_nxt)) begin
      seln_nxt[sel_idx_r] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r              <= SPH_IDLE;
      cnt_r                <= DIV_RST;
      edge_r               <= 4'h0;
      sh_r                 <= 8'h00;
      done_r               <= 1'b0;
      dev_serial_clock_pin <= 1'b0;
      dev_serial_in_pin    <= 1'b0;
      dev_select_in_pin_n  <= '1;
    end else begin
      state_r              <= state_nxt;
      cnt_r                <= cnt_nxt;
      edge_r               <= edge_nxt;
      sh_r                 <= sh_nxt;
      done_r               <= done_nxt;
      dev_serial_clock_pin <= sclk_nxt;
      dev_serial_in_pin    <= mosi_nxt;
      dev_select_in_pin_n  <= seln_nxt;
    end
  end

  // Helper for the checks: serial clock toggles since the byte started.
  logic [4:0] tog_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == SPH_SETUP) begin
      tog_r <= 5'h00;
    end else if (state_r == SPH_XFER && tick && en_nxt) begin
      tog_r <= tog_r + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_one_select: assert property ($countones(~dev_select_in_pin_n) <= 1)
    else $error("more than one slave selected");
  a_byte_toggles: assert property (done_r |-> tog_r == BYTE_EDGES)
    else $error("byte did not take sixteen clock edges");
  a_clock_idle_desel: assert property (
    (&dev_select_in_pin_n && $stable(cpol_r)) |-> dev_serial_clock_pin == cpol_r)
    else $error("clock not idle while deselected");
  a_clock_only_xfer: assert property (
    ($changed(dev_serial_clock_pin) && $past(state_r) != SPH_IDLE)
      |-> $past(state_r) == SPH_XFER)
    else $error("clock toggled outside a byte");
  a_data_change_edge: assert property (
    ($changed(dev_serial_in_pin) && $past(state_r) == SPH_XFER)
      |-> $changed(dev_serial_clock_pin) && $past(edge_r[0]) != $past(cpha_r))
    else $error("data changed on the sample edge");
  a_disabled_quiet: assert property (
    !en_r |-> &dev_select_in_pin_n && state_r == SPH_IDLE)
    else $error("link active while disabled");
  a_write_starts: assert property (
    tx_go |=> state_r == SPH_SETUP && sh_r == $past(wdata_r[7:0]) && !dev_select_in_pin_n[sel_idx_r])
    else $error("buffer write did not start a byte");
  a_stop_then_desel: assert property (
    (done_r && !hold_r && en_r) |-> !(&dev_select_in_pin_n) [*2])
    else $error("slave deselected before the clock stopped");
  a_full_on_done: assert property (done_r |-> full_r && rxbuf_r == sh_r)
    else $error("received byte not latched");
  a_collision_flag: assert property (tx_coll |=> write_collision_flag_r && !$rose(state_r == SPH_SETUP))
    else $error("write during transfer not flagged");

  c_byte_mode0: cover property (done_r && !cpol_r && !cpha_r);
  c_byte_mode3: cover property (done_r && cpol_r && cpha_r);
  c_collision: cover property (tx_coll);
  c_held_frame: cover property (tx_go && !(&dev_select_in_pin_n));
endmodule : sph_master

// ==== bench/sph_dev_model.sv ====
// Behavioural serial slave device standing on one select line of the host.
`timescale 1ns/1ps
module sph_dev_model (
  input  wire logic       aclk,    // Bench clock, used only to scramble a released output.
  input  wire logic       sclk,    // Serial clock from the host.
  input  wire logic       sdi,     // Data from the host.
  input  wire logic       sel_n,   // Select, active low.
  input  wire logic       cpol,    // Idle level of the serial clock.
  input  wire logic       cpha,    // Change on the leading edge when set.
  input  wire logic [7:0] tx_byte, // Byte loaded into the shifter at select or byte end.
  output logic            sdo,     // Data to the host.
  output logic [7:0]      rx_byte, // Last byte received.
  output int              n_rx     // Count of bytes received.
);
  logic [7:0] port_shift_register;
  logic [2:0] cnt;
  logic       lead;
  initial begin
    sdo = 1'b0;
    rx_byte = 8'h00;
    n_rx = 0;
    cnt = 3'h0;
    port_shift_register = 8'h00;
  end
  // There is no pull resistor, so a released output must not hold a usable level.
  always @(posedge aclk) if (sel_n) sdo <= ~sdo;
  always @(negedge sel_n) begin
    cnt = 3'h0;
    port_shift_register = tx_byte;
    if (!cpha) sdo = tx_byte[7];
  end
  always @(sclk) if (!sel_n) begin
    lead = (sclk !== cpol);
    if (lead == cpha) sdo = port_shift_register[7];
    else begin
      port_shift_register = {port_shift_register[6:0], sdi};
      cnt = cnt + 3'h1;
      if (cnt == 3'h0) begin
        rx_byte = port_shift_register;
        n_rx++;
        port_shift_register = tx_byte;
      end
    end
  end
endmodule : sph_dev_model

// ==== bench/sph_master_tb.sv ====
// Self-checking bench for the serial peripheral host.
`timescale 1ns/1ps
module sph_master_tb;
  import sph_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sclk, mosi, miso;
  logic        m_cpol, m_cpha, sclk_q, sel_q;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, sel_n;
  logic [1:0]  bresp, rresp;
  logic [7:0]  m_tx, m_rx;
  int          m_n, miscompares, n_compared, edges, gap, gap_last, rises, e0, r0, h;

  sph_master #(.NSEL(4)) DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .dev_serial_clock_pin(sclk), .dev_serial_in_pin(mosi),
    .dev_serial_out_pin(miso), .dev_select_in_pin_n(sel_n));
  sph_dev_model u_dev (.aclk(aclk), .sclk(sclk), .sdi(mosi), .sel_n(sel_n[2]),
    .cpol(m_cpol), .cpha(m_cpha), .tx_byte(m_tx), .sdo(miso), .rx_byte(m_rx), .n_rx(m_n));

  always #25 aclk = ~aclk;

  // Edge and gap counters let the bench judge the link without trusting the status bits.
  always @(posedge aclk) begin
    sclk_q <= sclk;
    sel_q <= sel_n[2];
    gap <= gap + 1;
    if (sclk !== sclk_q) begin
      edges <= edges + 1;
      gap_last <= gap + 1;
      gap <= 0;
    end
    if (sel_n[2] === 1'b1 && sel_q === 1'b0) rises <= rises + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd_reg(input logic [4:0] a, input logic [1:0] er, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    rd_reg(a, RESP_OKAY, rd);
    check(nm, rd, exp);
  endtask : rchk

  task automatic start_byte(input logic [7:0] hb, input logic [7:0] db);
    m_tx <= db;
    wr(OFF_TXDATA, {24'h0, hb}, RESP_OKAY);
    // Taken after the write so an idle level change from a prior control write is not counted.
    e0 = edges;
    rchk("status busy", OFF_STATUS, 32'h9);
    check("selects busy", {28'h0, sel_n}, 32'hb);
  endtask : start_byte

  task automatic finish_byte(input logic [7:0] hb, input logic [7:0] db, input logic [31:0] st);
    do rd_reg(OFF_STATUS, RESP_OKAY, rd);
    while (rd[ST_BUSY] === 1'b1);
    check("status done", rd, st);
    check("clock edges", 32'(edges - e0), 32'd16);
    check("half period", 32'(gap_last), 32'(h));
    check("device rx", {24'h0, m_rx}, {24'h0, hb});
    rchk("host rx", OFF_RXDATA, {24'h0, db});
  endtask : finish_byte

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, m_cpol, m_cpha} = '0;
    {awaddr, araddr, wdata, wstrb, m_tx} = '0;
    {miscompares, n_compared, edges, gap, gap_last, rises} = '0;
    h = 4;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wstrb <= 4'hf;
    @(posedge aclk);
    check("idle selects", {28'h0, sel_n}, 32'hf);
    check("idle clock", {31'h0, sclk}, 32'h0);
    rchk("ctrl reset", OFF_CTRL, 32'h0);
    rchk("div reset", OFF_DIV, {24'h0, DIV_RST});
    wr(OFF_STATUS, 32'hff, RESP_OKAY);
    rchk("status ro", OFF_STATUS, 32'h0);
    rchk("tx reads zero", OFF_TXDATA, 32'h0);
    wr(5'h14, 32'h1, RESP_SLVERR);
    rd_reg(5'h14, RESP_SLVERR, rd);
    check("unmapped data", rd, 32'h0);
    wr(OFF_TXDATA, 32'ha5, RESP_OKAY);
    rchk("disabled start", OFF_STATUS, 32'h0);
    for (int m = 0; m < 4; m++) begin
      h = m[0] ? 3 : 4;
      m_cpol <= m[0];
      m_cpha <= m[1];
      wr(OFF_DIV, 32'(h - 1), RESP_OKAY);
      rchk("div", OFF_DIV, 32'(h - 1));
      wr(OFF_CTRL, 32'h21 | (32'(m) << 1), RESP_OKAY);
      check("clock idle", {31'h0, sclk}, {31'h0, m[0]});
      start_byte(8'h96 ^ 8'(m), 8'h5a + 8'(m));
      finish_byte(8'h96 ^ 8'(m), 8'h5a + 8'(m), 32'h2);
      rchk("full cleared", OFF_STATUS, 32'h0);
    end
    // A second buffer write while busy must be dropped and flagged.
    wr(OFF_DIV, 32'h3, RESP_OKAY);
    h = 4;
    m_cpol <= 1'b0;
    m_cpha <= 1'b0;
    wr(OFF_CTRL, 32'h21, RESP_OKAY);
    start_byte(8'hc5, 8'h3a);
    wr(OFF_TXDATA, 32'h11, RESP_OKAY);
    rchk("collision busy", OFF_STATUS, 32'hd);
    finish_byte(8'hc5, 8'h3a, 32'h6);
    wr(OFF_TXDATA, 32'h22, RESP_OKAY);
    rchk("blocked start", OFF_STATUS, 32'h4);
    wr(OFF_STATUS, 32'h4, RESP_OKAY);
    rchk("collision clear", OFF_STATUS, 32'h0);
    // Two bytes inside one select period.
    // Hold lowers the select at once, and the device loads its shifter then.
    m_tx <= 8'hc3;
    wr(OFF_CTRL, 32'h29, RESP_OKAY);
    r0 = rises;
    start_byte(8'h3c, 8'hc3);
    m_tx <= 8'h81;
    finish_byte(8'h3c, 8'hc3, 32'ha);
    start_byte(8'h7e, 8'h81);
    finish_byte(8'h7e, 8'h81, 32'ha);
    check("held select", 32'(rises - r0), 32'h0);
    wr(OFF_CTRL, 32'h21, RESP_OKAY);
    check("released select", {28'h0, sel_n}, 32'hf);
    // A byte to another select line must leave this device untouched.
    r0 = m_n;
    wr(OFF_CTRL, 32'h11, RESP_OKAY);
    wr(OFF_TXDATA, 32'h55, RESP_OKAY);
    check("other select", {28'h0, sel_n}, 32'hd);
    do rd_reg(OFF_STATUS, RESP_OKAY, rd);
    while (rd[ST_BUSY] === 1'b1);
    check("ignored device", 32'(m_n - r0), 32'h0);
    rd_reg(OFF_RXDATA, RESP_OKAY, rd);
    // Clearing enable in mid-byte must drop the link at once.
    m_cpol <= 1'b1;
    wr(OFF_CTRL, 32'h23, RESP_OKAY);
    start_byte(8'hf0, 8'h0f);
    wr(OFF_CTRL, 32'h22, RESP_OKAY);
    check("abort selects", {28'h0, sel_n}, 32'hf);
    check("abort clock", {31'h0, sclk}, 32'h1);
    rchk("abort status", OFF_STATUS, 32'h0);
    give_verdict();
  end
endmodule : sph_master_tb
